// *** verilog/rsmc_defs.vh ***
`ifndef RSMC_DEFS_VH
`define RSMC_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RSMC_OFF_NODE_ID      6'h09
`define RSMC_OFF_CHANNEL      6'h0a
`define RSMC_OFF_IF_SETTING   6'h0b
`define RSMC_OFF_SYNTH_OFFSET 6'h0c
`define RSMC_OFF_CARRIER_HI   6'h0d
`define RSMC_OFF_CARRIER_MID  6'h0e
`define RSMC_OFF_CARRIER_LO   6'h0f
`define RSMC_OFF_BW_RATE_EXP  6'h10
`define RSMC_OFF_RATE_MANT    6'h11
// ----------------------------------------
// reset values
// ----------------------------------------
`define RSMC_RST_NODE_ID      8'h00
`define RSMC_RST_CHANNEL      8'h00
`define RSMC_RST_IF_TONE      5'h0f
`define RSMC_RST_IF_RSVD      1'h0
`define RSMC_RST_SYNTH_OFFSET 8'h00
`define RSMC_RST_CARRIER_HI   6'h1e
`define RSMC_RST_CARRIER_MID  8'hc4
`define RSMC_RST_CARRIER_LO   8'hec
`define RSMC_RST_BW_EXP       2'h2
`define RSMC_RST_BW_MANT      2'h0
`define RSMC_RST_RATE_EXP     4'hc
`define RSMC_RST_RATE_MANT    8'h22
// ----------------------------------------
// field positions
// ----------------------------------------
`define RSMC_IF_TONE_MSB      4
`define RSMC_IF_RSVD_BIT      5
`define RSMC_CARRIER_HI_MSB   5
`define RSMC_BW_EXP_MSB       7
`define RSMC_BW_EXP_LSB       6
`define RSMC_BW_MANT_MSB      5
`define RSMC_BW_MANT_LSB      4
`define RSMC_RATE_EXP_MSB     3
// ----------------------------------------
// address check modes and broadcast values
// ----------------------------------------
`define RSMC_ACM_NONE         2'h0
`define RSMC_ACM_NO_BCAST     2'h1
`define RSMC_ACM_BCAST_ZERO   2'h2
`define RSMC_ACM_BCAST_BOTH   2'h3
`define RSMC_BCAST_ZERO       8'h00
`define RSMC_BCAST_ONES       8'hff
`endif

// *** verilog/rsmc_config_regs.v ***
`include "rsmc_defs.vh"
`default_nettype none

module rsmc_config_regs (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        wr_en_i,
    input  wire        rd_en_i,
    input  wire [5:0]  addr_i,
    input  wire [7:0]  wr_data_i,
    output reg  [7:0]  rd_data_o,
    output wire        hit_o,
    input  wire [1:0]  address_check_mode_i,
    input  wire        rx_mode_i,
    input  wire        pkt_addr_valid_i,
    input  wire [7:0]  pkt_addr_i,
    output reg         pkt_addr_accept_o,
    output wire [7:0]  channel_index_o,
    output wire [4:0]  intermediate_tone_word_o,
    output wire [7:0]  synth_offset_word_o,
    output wire [23:0] carrier_synth_word_o,
    output reg  [31:0] synth_carrier_synth_word_word_o,
    output wire [1:0]  rx_bw_exponent_o,
    output wire [1:0]  rx_bw_mantissa_o,
    output wire [3:0]  symbol_rate_exponent_o,
    output wire [7:0]  symbol_rate_mantissa_o,
    output reg  [23:0] symbol_rate_word_o,
    output reg  [5:0]  bw_decim_o
);

// ----------------------------------------
// parameters
// ----------------------------------------
parameter [7:0] CHANNEL_INDEX_SPACING = 8'h01;

// ----------------------------------------
// register storage
// ----------------------------------------
reg [7:0] node_id_q;
reg [7:0] channel_q;
reg [4:0] tone_q;
reg       if_rsvd_q;
reg [7:0] offset_q;
reg [5:0] carrier_hi_q;
reg [7:0] carrier_mid_q;
reg [7:0] carrier_lo_q;
reg [1:0] bw_exp_q;
reg [1:0] bw_mant_q;
reg [3:0] rate_exp_q;
reg [7:0] rate_mant_q;

function sel;
    input [5:0] a;
    input [5:0] off;
    begin
        sel = (a == off);
    end
endfunction

assign hit_o = (addr_i >= `RSMC_OFF_NODE_ID) &&
               (addr_i <= `RSMC_OFF_RATE_MANT);

// ----------------------------------------
// host writes
// ----------------------------------------
// write strobes, one per register
wire we_node_id  = wr_en_i & sel(addr_i, `RSMC_OFF_NODE_ID);
wire we_channel  = wr_en_i & sel(addr_i, `RSMC_OFF_CHANNEL);
wire we_if       = wr_en_i & sel(addr_i, `RSMC_OFF_IF_SETTING);
wire we_offset   = wr_en_i & sel(addr_i, `RSMC_OFF_SYNTH_OFFSET);
wire we_carr_hi  = wr_en_i & sel(addr_i, `RSMC_OFF_CARRIER_HI);
wire we_carr_mid = wr_en_i & sel(addr_i, `RSMC_OFF_CARRIER_MID);
wire we_carr_lo  = wr_en_i & sel(addr_i, `RSMC_OFF_CARRIER_LO);
wire we_bw_rate  = wr_en_i & sel(addr_i, `RSMC_OFF_BW_RATE_EXP);
wire we_rate_mnt = wr_en_i & sel(addr_i, `RSMC_OFF_RATE_MANT);

// ----------------------------------------
// node address and channel
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i)
        node_id_q <= `RSMC_RST_NODE_ID;
    else if (we_node_id)
        node_id_q <= wr_data_i;
end

always @(posedge clk_i) begin
    if (reset_i)
        channel_q <= `RSMC_RST_CHANNEL;
    else if (we_channel)
        channel_q <= wr_data_i;
end

// ----------------------------------------
// intermediate tone and offset
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        tone_q    <= `RSMC_RST_IF_TONE;
        if_rsvd_q <= `RSMC_RST_IF_RSVD;
    end else if (we_if) begin
        tone_q    <= wr_data_i[`RSMC_IF_TONE_MSB:0];
        if_rsvd_q <= wr_data_i[`RSMC_IF_RSVD_BIT];
    end
end

always @(posedge clk_i) begin
    if (reset_i)
        offset_q <= `RSMC_RST_SYNTH_OFFSET;
    else if (we_offset)
        offset_q <= wr_data_i;
end

// ----------------------------------------
// carrier word bytes
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i)
        carrier_hi_q <= `RSMC_RST_CARRIER_HI;
    else if (we_carr_hi)
        carrier_hi_q <= wr_data_i[`RSMC_CARRIER_HI_MSB:0];
end

always @(posedge clk_i) begin
    if (reset_i)
        carrier_mid_q <= `RSMC_RST_CARRIER_MID;
    else if (we_carr_mid)
        carrier_mid_q <= wr_data_i;
end

always @(posedge clk_i) begin
    if (reset_i)
        carrier_lo_q <= `RSMC_RST_CARRIER_LO;
    else if (we_carr_lo)
        carrier_lo_q <= wr_data_i;
end

// ----------------------------------------
// bandwidth and symbol rate fields
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        bw_exp_q   <= `RSMC_RST_BW_EXP;
        bw_mant_q  <= `RSMC_RST_BW_MANT;
        rate_exp_q <= `RSMC_RST_RATE_EXP;
    end else if (we_bw_rate) begin
        bw_exp_q   <= wr_data_i[`RSMC_BW_EXP_MSB:`RSMC_BW_EXP_LSB];
        bw_mant_q  <= wr_data_i[`RSMC_BW_MANT_MSB:`RSMC_BW_MANT_LSB];
        rate_exp_q <= wr_data_i[`RSMC_RATE_EXP_MSB:0];
    end
end

always @(posedge clk_i) begin
    if (reset_i)
        rate_mant_q <= `RSMC_RST_RATE_MANT;
    else if (we_rate_mnt)
        rate_mant_q <= wr_data_i;
end

// ----------------------------------------
// host reads
// ----------------------------------------
// assembled read words, unused bits read zero
wire [7:0] if_read_w = {2'h0, if_rsvd_q, tone_q};
wire [7:0] hi_read_w = {2'h0, carrier_hi_q};
wire [7:0] bw_read_w = {bw_exp_q, bw_mant_q, rate_exp_q};

reg [7:0] rd_data_d;

always @* begin
    case (addr_i)
        `RSMC_OFF_NODE_ID:      rd_data_d = node_id_q;
        `RSMC_OFF_CHANNEL:      rd_data_d = channel_q;
        `RSMC_OFF_IF_SETTING:   rd_data_d = if_read_w;
        `RSMC_OFF_SYNTH_OFFSET: rd_data_d = offset_q;
        `RSMC_OFF_CARRIER_HI:   rd_data_d = hi_read_w;
        `RSMC_OFF_CARRIER_MID:  rd_data_d = carrier_mid_q;
        `RSMC_OFF_CARRIER_LO:   rd_data_d = carrier_lo_q;
        `RSMC_OFF_BW_RATE_EXP:  rd_data_d = bw_read_w;
        `RSMC_OFF_RATE_MANT:    rd_data_d = rate_mant_q;
        default:                rd_data_d = 8'h00;
    endcase
end

always @(posedge clk_i) begin
    if (reset_i)
        rd_data_o <= 8'h00;
    else if (rd_en_i)
        rd_data_o <= rd_data_d;
end

// ----------------------------------------
// field outputs
// ----------------------------------------
assign channel_index_o          = channel_q;
assign intermediate_tone_word_o = tone_q;
assign synth_offset_word_o      = offset_q;
assign carrier_synth_word_o     = {2'h0, carrier_hi_q,
                                   carrier_mid_q, carrier_lo_q};
assign rx_bw_exponent_o         = bw_exp_q;
assign rx_bw_mantissa_o         = bw_mant_q;
assign symbol_rate_exponent_o   = rate_exp_q;
assign symbol_rate_mantissa_o   = rate_mant_q;

// ----------------------------------------
// address filter
// ----------------------------------------
wire own_match  = (pkt_addr_i == node_id_q);
wire zero_match = (pkt_addr_i == `RSMC_BCAST_ZERO);
wire ones_match = (pkt_addr_i == `RSMC_BCAST_ONES);
reg  accept_d;

always @* begin
    accept_d = 1'b0;
    case (address_check_mode_i)
        `RSMC_ACM_NONE:       accept_d = 1'b1;
        `RSMC_ACM_NO_BCAST:   accept_d = own_match;
        `RSMC_ACM_BCAST_ZERO: accept_d = own_match | zero_match;
        `RSMC_ACM_BCAST_BOTH: accept_d = own_match | zero_match |
                                         ones_match;
        default:              accept_d = 1'b0;
    endcase
end

// verdict holds until the next address byte
always @(posedge clk_i) begin
    if (reset_i)
        pkt_addr_accept_o <= 1'b0;
    else if (pkt_addr_valid_i)
        pkt_addr_accept_o <= accept_d;
end

// ----------------------------------------
// derived synthesizer word, units xtal/2^16
// ----------------------------------------
// offset step is xtal/2^14 = 4 units; tone step is xtal/2^10 = 64 units
wire [31:0] base_w   = {8'h00, carrier_synth_word_o};
// full 16-bit product, no truncation of large spacings
wire [15:0] channel_index_prod_w = channel_q * CHANNEL_INDEX_SPACING;
wire [31:0] channel_index_w   = {8'h00, channel_index_prod_w, 8'h00};
wire [31:0] offs_w   = {{22{offset_q[7]}}, offset_q, 2'b00};
wire [31:0] tone_w   = {21'h000000, tone_q, 6'h00};

// sums wrap modulo 2^32
wire [31:0] tx_carrier_synth_word_w = base_w + channel_index_w + offs_w;
wire [31:0] rx_carrier_synth_word_w = tx_carrier_synth_word_w - tone_w;

always @(posedge clk_i) begin
    if (reset_i)
        synth_carrier_synth_word_word_o <= 32'h0000_0000;
    else if (rx_mode_i)
        synth_carrier_synth_word_word_o <= rx_carrier_synth_word_w;
    else
        synth_carrier_synth_word_word_o <= tx_carrier_synth_word_w;
end

// ----------------------------------------
// derived symbol rate
// ----------------------------------------
// hidden one above the stored mantissa; largest value fits 24 bits
wire [8:0]  rate_mant_full_w = {1'b1, rate_mant_q};
wire [23:0] rate_word_w      = {15'h0000, rate_mant_full_w} << rate_exp_q;

always @(posedge clk_i) begin
    if (reset_i)
        symbol_rate_word_o <= 24'h00_0000;
    else
        symbol_rate_word_o <= rate_word_w;
end

// ----------------------------------------
// derived decimation ratio
// ----------------------------------------
// 4 plus mantissa is the mantissa with a leading one
wire [2:0] bw_mant_full_w = {1'b1, bw_mant_q};
wire [5:0] bw_decim_w     = {3'h0, bw_mant_full_w} << bw_exp_q;

always @(posedge clk_i) begin
    if (reset_i)
        bw_decim_o <= 6'h00;
    else
        bw_decim_o <= bw_decim_w;
end

endmodule // rsmc_config_regs

`default_nettype wire

// *** tb/rsmc_config_regs_properties.sv ***
`default_nettype none
module rsmc_config_regs_checker #(
    parameter logic [7:0] CHANNEL_INDEX_SPACING = 8'h01
) (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        wr_en_i,
    input wire logic        rd_en_i,
    input wire logic [5:0]  addr_i,
    input wire logic [7:0]  wr_data_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        hit_o,
    input wire logic [1:0]  address_check_mode_i,
    input wire logic        rx_mode_i,
    input wire logic        pkt_addr_valid_i,
    input wire logic [7:0]  pkt_addr_i,
    input wire logic        pkt_addr_accept_o,
    input wire logic [7:0]  channel_index_o,
    input wire logic [4:0]  intermediate_tone_word_o,
    input wire logic [7:0]  synth_offset_word_o,
    input wire logic [23:0] carrier_synth_word_o,
    input wire logic [31:0] synth_carrier_synth_word_word_o,
    input wire logic [1:0]  rx_bw_exponent_o,
    input wire logic [1:0]  rx_bw_mantissa_o,
    input wire logic [3:0]  symbol_rate_exponent_o,
    input wire logic [7:0]  symbol_rate_mantissa_o,
    input wire logic [23:0] symbol_rate_word_o,
    input wire logic [5:0]  bw_decim_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] carrier_synth_word_exp;
    assign carrier_synth_word_exp = {8'h00, carrier_synth_word_o}
        + {24'h0, channel_index_o} * {24'h0, CHANNEL_INDEX_SPACING} * 32'd256
        + {{22{synth_offset_word_o[7]}}, synth_offset_word_o, 2'h0}
        - (rx_mode_i ? {21'h0, intermediate_tone_word_o, 6'h0} : 32'h0);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    chk_hi_read_zero: assert property (
        rd_en_i && addr_i == 6'h0d |=> rd_data_o[7:6] == 2'h0)
        else $error("carrier high byte top bits read set");
    chk_channel_index_write: assert property (
        wr_en_i && addr_i == 6'h0a |=> channel_index_o == $past(wr_data_i))
        else $error("channel index not written");
    chk_offset_write: assert property (
        wr_en_i && addr_i == 6'h0c |=> synth_offset_word_o == $past(wr_data_i))
        else $error("offset word not written");
    chk_tone_write: assert property (
        wr_en_i && addr_i == 6'h0b |=>
        {3'h0, intermediate_tone_word_o} == ($past(wr_data_i) & 8'h1f))
        else $error("tone word not written");
    chk_rate_word: assert property (!reset_i |=> symbol_rate_word_o ==
        ((24'd256 + $past(symbol_rate_mantissa_o)) << $past(symbol_rate_exponent_o)))
        else $error("symbol rate word wrong");
    chk_bw_decim: assert property (!reset_i |=> bw_decim_o ==
        ((6'd4 + $past(rx_bw_mantissa_o)) << $past(rx_bw_exponent_o)))
        else $error("decimation ratio wrong");
    chk_carrier_synth_word_word: assert property (
        !reset_i |=> synth_carrier_synth_word_word_o == $past(carrier_synth_word_exp))
        else $error("synth frequency word wrong");
    chk_no_check: assert property (
        pkt_addr_valid_i && address_check_mode_i == 2'h0 |=> pkt_addr_accept_o)
        else $error("packet refused with check off");
    chk_bcast_accept: assert property (pkt_addr_valid_i && (
        (address_check_mode_i == 2'h3 && pkt_addr_i == 8'hff) ||
        (address_check_mode_i[1] && pkt_addr_i == 8'h00)) |=> pkt_addr_accept_o)
        else $error("broadcast refused");
    chk_unmapped_zero: assert property (
        rd_en_i && !hit_o |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    cov_unmapped: cover property (rd_en_i && !hit_o);
    cov_bcast: cover property (pkt_addr_valid_i && address_check_mode_i == 2'h3);
    cov_rx_write: cover property (rx_mode_i && wr_en_i);
endmodule // rsmc_config_regs_checker
bind rsmc_config_regs rsmc_config_regs_checker #(.CHANNEL_INDEX_SPACING(CHANNEL_INDEX_SPACING))
    rsmc_config_regs_checker_inst (.clk_i, .reset_i, .wr_en_i, .rd_en_i,
    .addr_i, .wr_data_i, .rd_data_o, .hit_o, .address_check_mode_i,
    .rx_mode_i, .pkt_addr_valid_i, .pkt_addr_i, .pkt_addr_accept_o,
    .channel_index_o, .intermediate_tone_word_o, .synth_offset_word_o,
    .carrier_synth_word_o, .synth_carrier_synth_word_word_o, .rx_bw_exponent_o,
    .rx_bw_mantissa_o, .symbol_rate_exponent_o, .symbol_rate_mantissa_o,
    .symbol_rate_word_o, .bw_decim_o);
`default_nettype wire

// *** tb/rsmc_host_model.sv ***
`default_nettype none
module rsmc_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rd_data_i,
    output var  logic       wr_en_o = 1'b0,
    output var  logic       rd_en_o = 1'b0,
    output var  logic [5:0] addr_o = 6'h00,
    output var  logic [7:0] wr_data_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // released lines show inverse of last value
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        addr_o <= a;
        wr_data_o <= d;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        addr_o <= ~a;
        wr_data_o <= ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_en_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        #1 d = rd_data_i;
    endtask
endmodule // rsmc_host_model
`default_nettype wire

// *** tb/rsmc_config_regs_bench.sv ***
`default_nettype none
module rsmc_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, reset_i = 1'b1, rx_mode_i = 1'b0;
    logic pkt_addr_valid_i = 1'b0, wr_en_i, rd_en_i, hit_o, pkt_addr_accept_o;
    logic [1:0] address_check_mode_i = 2'h0, rx_bw_exponent_o, rx_bw_mantissa_o;
    logic [7:0] pkt_addr_i = 8'h00, wr_data_i, rd_data_o, channel_index_o;
    logic [7:0] synth_offset_word_o, symbol_rate_mantissa_o;
    logic [5:0] addr_i, bw_decim_o;
    logic [4:0] intermediate_tone_word_o;
    logic [3:0] symbol_rate_exponent_o;
    logic [23:0] carrier_synth_word_o, symbol_rate_word_o;
    logic [31:0] synth_carrier_synth_word_word_o;
    int bad_count = 0, n_checks = 0;
    logic [7:0] dflt [9] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h1e, 8'hc4, 8'hec,
                             8'h8c, 8'h22};
    logic [7:0] wmask [10] = '{8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff,
                               8'hff, 8'hff, 8'hff, 8'h00};
    logic [7:0] pa [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};
    logic [15:0] acc = 16'h731f;
    always #2.5 clk_i = ~clk_i;
    rsmc_config_regs rsmc_config_regs_inst (.clk_i, .reset_i, .wr_en_i,
        .rd_en_i, .addr_i, .wr_data_i, .rd_data_o, .hit_o, .address_check_mode_i,
        .rx_mode_i, .pkt_addr_valid_i, .pkt_addr_i, .pkt_addr_accept_o,
        .channel_index_o, .intermediate_tone_word_o, .synth_offset_word_o,
        .carrier_synth_word_o, .synth_carrier_synth_word_word_o, .rx_bw_exponent_o,
        .rx_bw_mantissa_o, .symbol_rate_exponent_o, .symbol_rate_mantissa_o,
        .symbol_rate_word_o, .bw_decim_o);
    rsmc_host_model rsmc_host_model_inst (.clk_i, .rd_data_i(rd_data_o),
        .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
        .wr_data_o(wr_data_i));
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_regs;
        logic [7:0] d;
        for (int i = 0; i < 9; i++) begin
            rsmc_host_model_inst.rd(6'h09 + 6'(i), d);
            ck(d, dflt[i]);
        end
        for (int i = 0; i < 10; i++) begin
            rsmc_host_model_inst.wr(6'h09 + 6'(i), 8'hff);
            rsmc_host_model_inst.rd(6'h09 + 6'(i), d);
            ck(d, wmask[i]);
        end
    endtask
    task automatic t_derived;
        rsmc_host_model_inst.wr(6'h0d, 8'h21);
        rsmc_host_model_inst.wr(6'h0e, 8'h65);
        rsmc_host_model_inst.wr(6'h0f, 8'h6a);
        rsmc_host_model_inst.wr(6'h0a, 8'h03);
        rsmc_host_model_inst.wr(6'h0c, 8'h80);
        rsmc_host_model_inst.wr(6'h0b, 8'h0a);
        rsmc_host_model_inst.wr(6'h10, 8'h5b);
        rsmc_host_model_inst.wr(6'h11, 8'h3c);
        repeat (2) @(posedge clk_i);
        #1 ck(carrier_synth_word_o, 32'h0021656a);
        ck(synth_carrier_synth_word_word_o, 32'h0021666a);
        ck(intermediate_tone_word_o, 32'h0a);
        ck(bw_decim_o, 32'h0a);
        ck(symbol_rate_exponent_o, 32'h0b);
        ck(symbol_rate_word_o, 32'h0009e000);
        @(posedge clk_i);
        rx_mode_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 ck(synth_carrier_synth_word_word_o, 32'h002163ea);
    endtask
    task automatic t_filter;
        rsmc_host_model_inst.wr(6'h09, 8'h5a);
        for (int m = 0; m < 4; m++) for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            address_check_mode_i <= 2'(m);
            pkt_addr_valid_i <= 1'b1;
            pkt_addr_i <= pa[k];
            @(posedge clk_i);
            pkt_addr_valid_i <= 1'b0;
            #1 ck(pkt_addr_accept_o, acc[4 * m + k]);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_derived();
        t_filter();
        end_sim();
    end
    initial begin
        #20us;
        bad_count++;
        end_sim();
    end
endmodule // rsmc_config_regs_bench
`default_nettype wire
